// ---- srcp_defs.vh ----
`ifndef SRCP_DEFS_VH
`define SRCP_DEFS_VH
// =====================================================================
// serial framing
`define SRCP_CLK_HZ 20000000
`define SRCP_BAUD_9600 3'h0
`define SRCP_BAUD_19200 3'h1
`define SRCP_BAUD_38400 3'h2
`define SRCP_BAUD_57600 3'h3
`define SRCP_BAUD_115200 3'h4
`define SRCP_DIV_W 12
`define SRCP_DIV_9600 12'd2083
`define SRCP_DIV_19200 12'd1042
`define SRCP_DIV_38400 12'd521
`define SRCP_DIV_57600 12'd347
`define SRCP_DIV_115200 12'd174
`define SRCP_LAST_BIT 4'h9
// =====================================================================
// protocol bytes
`define SRCP_OP_WRITE 8'h57
`define SRCP_OP_READ 8'h52
`define SRCP_ACK 8'h06
`define SRCP_NAK 8'h15
`define SRCP_ERR_NONE 8'h00
`define SRCP_ERR_INVALID 8'h01
`define SRCP_ERR_TIMEOUT 8'h02
`define SRCP_ERR_CHECKSUM 8'h03
`define SRCP_ERR_BELOW_MIN 8'h04
`define SRCP_ERR_ABOVE_MAX 8'h05
`define SRCP_ERR_GAIN 8'h06
`define SRCP_ERR_SUPERVISOR 8'h07
`define SRCP_ERR_MODE 8'h08
// =====================================================================
// configuration memory
`define SRCP_WS_AW 4
`define SRCP_WS_DEPTH 16
`define SRCP_SEG_FACTORY 3'h0
`define SRCP_SEG_USER_MAX 3'h4
`define SRCP_MFG_PAGE 4'h7
`define SRCP_LOCAL_PAGE 4'h6
`define SRCP_REG_SET_SEL 8'h60
`define SRCP_REG_SET_LOAD 8'h64
`define SRCP_REG_SET_SAVE 8'h68
`define SRCP_REG_BAUD 8'h40
`define SRCP_REG_SUPER 8'h44
`define SRCP_REG_BOOT 8'h48
// =====================================================================
// time-out between command bytes
`define SRCP_TIMEOUT_MS 100
`define SRCP_TIMEOUT_CYC (`SRCP_CLK_HZ / 1000 * `SRCP_TIMEOUT_MS)
`endif

// ---- srcp_port.v ----
`timescale 1ns/1ps
`include "srcp_defs.vh"
module srcp_port #(
  parameter TIMEOUT_CYC = `SRCP_TIMEOUT_CYC
) (
  input wire CLK_SYS,
  input wire RESET,
  input wire RXD,
  output reg TXD,
  output wire BUSY,
  output reg [2:0] BOOT_SEGMENT
);
  localparam ST_BOOT = 3'h0;
  localparam ST_CMD = 3'h1;
  localparam ST_EXEC = 3'h2;
  localparam ST_COPY = 3'h3;
  localparam ST_RESP = 3'h4;
  // ===================================================================
  // storage: workspace and five segments, flattened by index
  reg [31:0] ws [0:`SRCP_WS_DEPTH-1];
  reg [31:0] seg [0:5*`SRCP_WS_DEPTH-1];
  reg [2:0] baud_sel;
  reg supervisor;
  reg [2:0] set_sel;
  reg [11:0] div;
  always @* begin
    case (baud_sel)
      `SRCP_BAUD_9600: div = `SRCP_DIV_9600;
      `SRCP_BAUD_19200: div = `SRCP_DIV_19200;
      `SRCP_BAUD_38400: div = `SRCP_DIV_38400;
      `SRCP_BAUD_57600: div = `SRCP_DIV_57600;
      default: div = `SRCP_DIV_115200;
    endcase
  end
  // ===================================================================
  // receiver
  reg rx_s1, rx_s2;
  reg [11:0] rx_cnt;
  reg [3:0] rx_bit;
  reg rx_act;
  reg [7:0] rx_sh;
  reg rx_vld;
  reg [7:0] rx_byte;
  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_cnt <= 12'h000;
      rx_bit <= 4'h0;
      rx_act <= 1'b0;
      rx_sh <= 8'h00;
      rx_vld <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_s1 <= RXD;
      rx_s2 <= rx_s1;
      rx_vld <= 1'b0;
      if (!rx_act) begin
        if (!rx_s2) begin
          rx_act <= 1'b1;
          rx_bit <= 4'h0;
          rx_cnt <= {1'b0, div[11:1]};
        end
      end else if (rx_cnt == 12'h000) begin
        rx_cnt <= div;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rx_s2) begin
          rx_act <= 1'b0;
        end else if (rx_bit == `SRCP_LAST_BIT) begin
          rx_act <= 1'b0;
          if (rx_s2) begin
            rx_vld <= 1'b1;
            rx_byte <= rx_sh;
          end
        end else begin
          rx_sh <= {rx_s2, rx_sh[7:1]};
        end
      end else begin
        rx_cnt <= rx_cnt - 12'h001;
      end
    end
  end
  // ===================================================================
  // transmitter
  reg [11:0] tx_cnt;
  reg [3:0] tx_bit;
  reg [8:0] tx_sh;
  reg tx_act;
  reg tx_go;
  reg [7:0] tx_byte;
  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      TXD <= 1'b1;
      tx_cnt <= 12'h000;
      tx_bit <= 4'h0;
      tx_sh <= 9'h1FF;
      tx_act <= 1'b0;
    end else if (!tx_act) begin
      TXD <= 1'b1;
      if (tx_go) begin
        tx_act <= 1'b1;
        TXD <= 1'b0;
        tx_sh <= {1'b1, tx_byte};
        tx_bit <= 4'h0;
        tx_cnt <= div;
      end
    end else if (tx_cnt == 12'h000) begin
      tx_cnt <= div;
      tx_bit <= tx_bit + 4'h1;
      if (tx_bit == `SRCP_LAST_BIT) begin
        tx_act <= 1'b0;
      end else begin
        TXD <= tx_sh[0];
        tx_sh <= {1'b1, tx_sh[8:1]};
      end
    end else begin
      tx_cnt <= tx_cnt - 12'h001;
    end
  end
  // ===================================================================
  // command interpreter
  reg [2:0] st;
  reg [2:0] nbyte;
  reg [7:0] op;
  reg [15:0] addr;
  reg [31:0] data;
  reg [39:0] resp;
  reg [2:0] resp_len;
  reg [31:0] idle_cnt;
  reg [4:0] cp_idx;
  reg cp_save;
  reg [2:0] cp_seg;
  wire [6:0] cp_base = {cp_seg, 4'h0} + {3'h0, cp_idx[3:0]};
  wire mapped = (addr[15:12] != `SRCP_MFG_PAGE) && (addr[15:12] != `SRCP_LOCAL_PAGE);
  wire [3:0] widx = addr[5:2];
  assign BUSY = (st != ST_CMD);
  integer i;
  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      st <= ST_BOOT;
      nbyte <= 3'h0;
      op <= 8'h00;
      addr <= 16'h0000;
      data <= 32'h0000_0000;
      resp <= 40'h0;
      resp_len <= 3'h0;
      idle_cnt <= 32'h0;
      cp_idx <= 5'h00;
      cp_save <= 1'b0;
      cp_seg <= `SRCP_SEG_FACTORY;
      baud_sel <= `SRCP_BAUD_115200;
      supervisor <= 1'b0;
      set_sel <= `SRCP_SEG_FACTORY;
      BOOT_SEGMENT <= `SRCP_SEG_FACTORY;
      tx_go <= 1'b0;
      tx_byte <= 8'hFF;
      for (i = 0; i < `SRCP_WS_DEPTH; i = i + 1) ws[i] <= 32'h0;
      for (i = 0; i < 5*`SRCP_WS_DEPTH; i = i + 1) seg[i] <= 32'h0;
    end else begin
      tx_go <= 1'b0;
      case (st)
        ST_BOOT: begin
          cp_seg <= BOOT_SEGMENT;
          cp_save <= 1'b0;
          cp_idx <= 5'h00;
          st <= ST_COPY;
        end
        ST_CMD: begin
          if (rx_vld) begin
            idle_cnt <= 32'h0;
            nbyte <= nbyte + 3'h1;
            case (nbyte)
              3'h0: op <= rx_byte;
              3'h1: addr[15:8] <= rx_byte;
              3'h2: addr[7:0] <= rx_byte;
              default: data <= {data[23:0], rx_byte};
            endcase
            if (nbyte == 3'h0 && rx_byte != `SRCP_OP_READ && rx_byte != `SRCP_OP_WRITE) begin
              resp <= {`SRCP_NAK, `SRCP_ERR_INVALID, 24'h0};
              resp_len <= 3'h2;
              nbyte <= 3'h0;
              st <= ST_RESP;
            end else if ((nbyte == 3'h2 && op == `SRCP_OP_READ) || nbyte == 3'h6) begin
              nbyte <= 3'h0;
              st <= ST_EXEC;
            end
          end else if (nbyte != 3'h0) begin
            idle_cnt <= idle_cnt + 32'h1;
            if (idle_cnt == TIMEOUT_CYC) begin
              resp <= {`SRCP_NAK, `SRCP_ERR_TIMEOUT, 24'h0};
              resp_len <= 3'h2;
              nbyte <= 3'h0;
              idle_cnt <= 32'h0;
              st <= ST_RESP;
            end
          end
        end
        ST_EXEC: begin
          st <= ST_RESP;
          if (op == `SRCP_OP_READ) begin
            resp_len <= 3'h5;
            if (addr[15:12] == `SRCP_LOCAL_PAGE && addr[7:0] == `SRCP_REG_SET_SEL)
              resp <= {`SRCP_ACK, 29'h0, set_sel};
            else if (addr[15:12] == `SRCP_LOCAL_PAGE && addr[7:0] == `SRCP_REG_BAUD)
              resp <= {`SRCP_ACK, 29'h0, baud_sel};
            else if (addr[15:12] == `SRCP_LOCAL_PAGE && addr[7:0] == `SRCP_REG_BOOT)
              resp <= {`SRCP_ACK, 29'h0, BOOT_SEGMENT};
            else if (mapped && addr[15:6] == 10'h0)
              resp <= {`SRCP_ACK, ws[widx]};
            else
              resp <= {`SRCP_ACK, 32'h0};
          end else begin
            resp <= {`SRCP_ACK, 32'h0};
            resp_len <= 3'h1;
            if (addr[15:12] == `SRCP_MFG_PAGE) begin
              if (!supervisor) begin
                resp <= {`SRCP_NAK, `SRCP_ERR_SUPERVISOR, 24'h0};
                resp_len <= 3'h2;
              end
            end else if (addr[15:12] == `SRCP_LOCAL_PAGE) begin
              case (addr[7:0])
                `SRCP_REG_SET_SEL: begin
                  if (data[2:0] > `SRCP_SEG_USER_MAX) begin
                    resp <= {`SRCP_NAK, `SRCP_ERR_ABOVE_MAX, 24'h0};
                    resp_len <= 3'h2;
                  end else set_sel <= data[2:0];
                end
                `SRCP_REG_SET_LOAD: begin
                  cp_seg <= set_sel;
                  cp_save <= 1'b0;
                  cp_idx <= 5'h00;
                  st <= ST_COPY;
                end
                `SRCP_REG_SET_SAVE: begin
                  if (set_sel == `SRCP_SEG_FACTORY && !supervisor) begin
                    resp <= {`SRCP_NAK, `SRCP_ERR_SUPERVISOR, 24'h0};
                    resp_len <= 3'h2;
                  end else begin
                    cp_seg <= set_sel;
                    cp_save <= 1'b1;
                    cp_idx <= 5'h00;
                    st <= ST_COPY;
                  end
                end
                `SRCP_REG_BAUD: begin
                  if (data[2:0] > `SRCP_BAUD_115200) begin
                    resp <= {`SRCP_NAK, `SRCP_ERR_ABOVE_MAX, 24'h0};
                    resp_len <= 3'h2;
                  end else baud_sel <= data[2:0];
                end
                `SRCP_REG_SUPER: supervisor <= data[0];
                `SRCP_REG_BOOT: begin
                  if (data[2:0] > `SRCP_SEG_USER_MAX) begin
                    resp <= {`SRCP_NAK, `SRCP_ERR_ABOVE_MAX, 24'h0};
                    resp_len <= 3'h2;
                  end else BOOT_SEGMENT <= data[2:0];
                end
                default: ;
              endcase
            end else if (addr[15:6] == 10'h0) begin
              ws[widx] <= data;
            end
          end
        end
        ST_COPY: begin
          if (cp_save) seg[cp_base] <= ws[cp_idx[3:0]];
          else ws[cp_idx[3:0]] <= seg[cp_base];
          cp_idx <= cp_idx + 5'h01;
          if (cp_idx[3:0] == 4'hF) begin
            if (resp_len == 3'h0) st <= ST_CMD;
            else st <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (resp_len == 3'h0) begin
            if (!tx_act && !tx_go) st <= ST_CMD;
          end else if (!tx_act && !tx_go) begin
            tx_byte <= resp[39:32];
            tx_go <= 1'b1;
            resp <= {resp[31:0], 8'h00};
            resp_len <= resp_len - 3'h1;
          end
        end
        default: st <= ST_CMD;
      endcase
    end
  end
endmodule // srcp_port

// ---- srcp_port_assertions.sv ----
`timescale 1ns/1ps
module srcp_port_checker #(
  parameter TIMEOUT_CYC = 2000
) (
  input wire CLK_SYS,
  input wire RESET,
  input wire RXD,
  input wire TXD,
  input wire BUSY,
  input wire [2:0] BOOT_SEGMENT
);
  // =====================================================================
  // low run length on the serial output
  logic [11:0] low_run;
  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      low_run <= 12'h000;
    end else begin
      low_run <= TXD ? 12'h000 : low_run + 12'h001;
    end
  end
  // =====================================================================
  // properties
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  sequence s_boot_copy;
    BUSY [*8];
  endsequence
  sequence s_boot_done;
    ##[1:40] !BUSY;
  endsequence
  a_idle_line_high: assert property (!BUSY |-> TXD)
    else $error("serial output low while not busy");
  a_start_when_busy: assert property ($fell(TXD) |-> BUSY)
    else $error("start bit outside an answer");
  a_answer_soon: assert property ($rose(BUSY) |-> ##[1:40] !TXD)
    else $error("no answer after command");
  a_bit_length: assert property ($rose(TXD) |-> (low_run % 175) == 0)
    else $error("low run not whole bit times");
  a_frame_bound: assert property ($rose(TXD) |-> low_run >= 12'd175 && low_run <= 12'd1575)
    else $error("low run outside one character");
  a_boot_range: assert property (BOOT_SEGMENT <= 3'h4)
    else $error("boot segment out of range");
  a_boot_hold: assert property (!$stable(BOOT_SEGMENT) |-> BUSY)
    else $error("boot segment changed while idle");
  a_boot_copy: assert property ($fell(RESET) |-> s_boot_copy)
    else $error("boot copy too short");
  a_boot_end: assert property ($fell(RESET) |-> s_boot_done)
    else $error("boot copy too long");
endmodule // srcp_port_checker

bind srcp_port srcp_port_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.CLK_SYS(CLK_SYS), .RESET(RESET), .RXD(RXD),
  .TXD(TXD), .BUSY(BUSY), .BOOT_SEGMENT(BOOT_SEGMENT));

// ---- srcp_host.sv ----
`timescale 1ns/1ps
module srcp_host #(
  parameter int BIT = 175
) (
  input wire logic clk,
  input wire logic from_dev,
  output logic to_dev
);
  logic [7:0] got[$];
  logic [7:0] sh;
  initial to_dev = 1'b1;
  // =====================================================================
  // sender: start, eight data lsb first, stop, 115200 rate
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      to_dev <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask
  // =====================================================================
  // receiver: mid-bit sampling, bad stop gives unknown byte
  always begin
    @(posedge clk iff from_dev === 1'b0);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      sh[i] = from_dev;
    end
    repeat (BIT) @(posedge clk);
    got.push_back(from_dev === 1'b1 ? sh : 8'hXX);
  end
endmodule // srcp_host

// ---- srcp_port_test.sv ----
`timescale 1ns/1ps
module srcp_port_test;
  logic clk_sys;
  logic reset;
  wire rxd;
  wire txd;
  wire busy;
  wire [2:0] boot_segment;
  int n_errors = 0;
  int tests_run = 0;
  always #25 clk_sys = ~clk_sys;
  srcp_port #(.TIMEOUT_CYC(2000)) dut (.CLK_SYS(clk_sys), .RESET(reset), .RXD(rxd), .TXD(txd), .BUSY(busy),
    .BOOT_SEGMENT(boot_segment));
  srcp_host host (.clk(clk_sys), .from_dev(txd), .to_dev(rxd));
  // =====================================================================
  // shared tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [55:0] cmd, input int ntx, input logic [39:0] rsp, input int nrx);
    int k;
    for (int i = ntx; i > 0; i--) begin
      host.send_byte(cmd[8*i-1 -: 8]);
    end
    for (int i = nrx; i > 0; i--) begin
      for (k = 0; k < 30000 && host.got.size() == 0; k++) begin
        @(posedge clk_sys);
      end
      check(host.got.size() > 0 ? host.got.pop_front() : 8'hXX, rsp[8*i-1 -: 8]);
    end
    for (k = 0; k < 2000 && busy !== 1'b0; k++) begin
      @(posedge clk_sys);
    end
    check({7'h00, busy}, 8'h00);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // =====================================================================
  // scenarios
  task automatic t_write_read();
    xfer(56'h57000811223344, 7, 40'h06, 1);
    xfer(56'h520008, 3, 40'h0611223344, 5);
    $display("test write_read done");
  endtask
  task automatic t_unmapped();
    xfer(56'h520410, 3, 40'h0600000000, 5);
    $display("test unmapped done");
  endtask
  task automatic t_bad_opcode();
    xfer(56'h41, 1, 40'h1501, 2);
    $display("test bad_opcode done");
  endtask
  task automatic t_mfg_write();
    xfer(56'h57700000000001, 7, 40'h1507, 2);
    $display("test mfg_write done");
  endtask
  task automatic t_timeout();
    xfer(56'h52, 1, 40'h1502, 2);
    $display("test timeout done");
  endtask
  task automatic t_boot_select();
    check({5'h00, boot_segment}, 8'h00);
    xfer(56'h57604800000001, 7, 40'h06, 1);
    check({5'h00, boot_segment}, 8'h01);
    $display("test boot_select done");
  endtask
  // =====================================================================
  // main sequence and watchdog
  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    for (int k = 0; k < 100 && busy !== 1'b0; k++) begin
      @(posedge clk_sys);
    end
    check({7'h00, busy}, 8'h00);
    t_write_read();
    t_unmapped();
    t_bad_opcode();
    t_mfg_write();
    t_timeout();
    t_boot_select();
    tally_and_finish();
  end
  initial begin
    repeat (95000) @(posedge clk_sys);
    n_errors++;
    tally_and_finish();
  end
endmodule // srcp_port_test
